// File: design/pwm_pkg.sv
// constants for the capture/compare/pwm unit in pwm mode
// assumes an 8-bit register port and a 50 MHz system clock
package pwm_pkg;
    // register indexes on the plain register port
    localparam logic [3:0] ADDR_TB_A_COUNT = 4'h0;
    localparam logic [3:0] ADDR_TB_A_PERIOD = 4'h1;
    localparam logic [3:0] ADDR_TB_A_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_TB_B_COUNT = 4'h3;
    localparam logic [3:0] ADDR_TB_B_PERIOD = 4'h4;
    localparam logic [3:0] ADDR_TB_B_CONTROL = 4'h5;
    localparam logic [3:0] ADDR_U4_DUTY_LOW = 4'h6;
    localparam logic [3:0] ADDR_U4_DUTY_HIGH = 4'h7;
    localparam logic [3:0] ADDR_U5_DUTY_LOW = 4'h8;
    localparam logic [3:0] ADDR_U5_DUTY_HIGH = 4'h9;
    localparam logic [3:0] ADDR_U4_CONTROL = 4'hA;
    localparam logic [3:0] ADDR_U5_CONTROL = 4'hB;
    localparam logic [3:0] ADDR_OPEN_DRAIN = 4'hC;
    localparam logic [3:0] ADDR_TB_ASSIGN = 4'hD;
    // timebase control fields
    localparam int PRESCALE_LSB = 0;
    localparam int RUN_BIT = 2;
    localparam int POSTSCALE_LSB = 3;
    localparam logic [7:0] TB_CONTROL_MASK = 8'h7F;
    // unit control fields
    localparam int DUTY_LOW_BITS_LSB = 4;
    localparam int MODE_LSB = 0;
    localparam logic [7:0] UNIT_CONTROL_MASK = 8'h3F;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;
    // open-drain select bits
    localparam int OD_UNIT_FOUR_BIT = 3;
    localparam int OD_UNIT_FIVE_BIT = 4;
    localparam logic [7:0] OPEN_DRAIN_MASK = 8'h1F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    // each timer increment is four oscillator phases
    localparam int PHASES_PER_TICK = 4;
    localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
    localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
endpackage

// File: design/pwm_timebase.sv
// one 8-bit pwm timebase: prescaler, counter, period match, postscaler
// assumes clk_i is the oscillator; ce_i freezes it
`timescale 1ns/1ps
module pwm_timebase
    import pwm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // software access
    input wire logic count_we_i,
    input wire logic control_we_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] period_i,
    input wire logic [7:0] control_i,
    // timebase state
    output logic [7:0] count_o,
    output logic [1:0] fine_o,
    output logic restart_o,
    output logic post_event_o
);
    typedef struct packed {
        logic [1:0] phase;
        logic [3:0] pre;
        logic [7:0] count;
        logic [3:0] post;
        logic post_event;
    } tb_state_t;

    tb_state_t cur_ff, nxt_ff;
    logic [1:0] presc;
    logic tick;
    logic run;

    always_comb begin
        presc = control_i[PRESCALE_LSB +: 2];
        run = control_i[RUN_BIT];
        tick = 1'b0;
        if (cur_ff.phase == 2'(PHASES_PER_TICK - 1)) begin
            case (presc)
                PRESCALE_DIV1: tick = 1'b1;
                PRESCALE_DIV4: tick = (cur_ff.pre[1:0] == 2'h3);
                default: tick = (cur_ff.pre == 4'hF); // (R14)
            endcase
        end
    end

    // restart fires on the increment after count equals period
    assign restart_o = run && tick && (cur_ff.count == period_i); // (R2)
    assign count_o = cur_ff.count;
    // low two compare bits: phase at 1:1, prescaler bits otherwise
    assign fine_o = (presc == PRESCALE_DIV1) ? cur_ff.phase
                  : (presc == PRESCALE_DIV4) ? cur_ff.pre[1:0] : cur_ff.pre[3:2]; // (R11)
    assign post_event_o = cur_ff.post_event;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.post_event = 1'b0;
        if (run) begin
            nxt_ff.phase = cur_ff.phase + 2'h1;
            if (cur_ff.phase == 2'(PHASES_PER_TICK - 1)) begin
                nxt_ff.pre = tick ? 4'h0 : cur_ff.pre + 4'h1;
            end
        end
        if (tick && run) begin
            if (restart_o) begin
                nxt_ff.count = 8'h00; // (R2)
                // postscaler counts periods only; it never gates restart
                if (cur_ff.post == control_i[POSTSCALE_LSB +: 4]) begin // (R5)
                    nxt_ff.post = 4'h0;
                    nxt_ff.post_event = 1'b1;
                end else begin
                    nxt_ff.post = cur_ff.post + 4'h1;
                end
            end else begin
                nxt_ff.count = cur_ff.count + 8'h01;
            end
        end
        if (control_we_i) begin
            nxt_ff.pre = 4'h0;
            nxt_ff.post = 4'h0;
        end
        if (count_we_i) begin
            nxt_ff.count = wdata_i;
            nxt_ff.pre = 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff <= '0;
        end else if (ce_i) begin
            cur_ff <= nxt_ff;
        end
    end
endmodule

// File: design/pwm_unit.sv
// What this block does
// (R1) period is (period+1) times four oscillator clocks times prescale
// (R2) count equal to period clears the counter on the next increment
// (R3) output goes high at each restart unless duty is zero
// (R4) restart copies the written duty into the active duty buffer
// (R5) postscaler never affects pwm period or frequency
// (R6) duty is ten bits: low byte register high, control bits 5:4 low
// (R7) high time is duty times one oscillator clock times prescale
// (R8) duty writes take effect only after the current period ends
// (R9) in pwm mode the duty high byte ignores software writes
// (R10) duty double-buffered in high byte plus a hidden two-bit latch
// (R11) output clears when active duty equals count with two fine bits
// (R12) duty beyond period never clears, output stays high all period
// (R13) software sets period, duty, direction, timer, then pwm mode
// (R14) prescaler divides by 1, 4 or 16 from its select field
// (R15) clearing unit control forces the unit output latch low
// (R16) software clears the port direction bit so the pin drives
// (R17) each unit takes its timebase from one of two timer pairs
// (R18) open-drain select drives low only, high left to a pull-up
//
// two pwm units on two shared timebases behind an 8-bit register port
// assumes single-cycle strobes from a master on clk_i
`timescale 1ns/1ps
module pwm_unit
    import pwm_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // port direction for the shared pins, 1 means input
    input wire logic [1:0] port_direction_i,
    // pwm pins, unit four is bit 0
    output logic [1:0] pwm_o,
    output logic [1:0] pwm_oe_o,
    // timer postscaler events
    output logic [1:0] post_event_o
);
    typedef struct packed {
        logic [1:0][7:0] period;
        logic [1:0][7:0] tb_control;
        logic [1:0][7:0] duty_low;
        logic [1:0][7:0] duty_high;
        logic [1:0][1:0] duty_hidden;
        logic [1:0][7:0] unit_control;
        logic [7:0] open_drain;
        logic [1:0] assign_b;
        logic [1:0] out_latch;
        logic [1:0] restart_d;
        logic [7:0] rdata;
    } unit_state_t;

    unit_state_t cur_ff, nxt_ff;
    logic [1:0][7:0] tb_count;
    logic [1:0][1:0] tb_fine;
    logic [1:0] tb_restart;
    logic [1:0] count_we;
    logic [1:0] control_we;
    logic [1:0] is_pwm;
    logic [1:0] sel_restart;
    logic [1:0][9:0] sel_count;
    logic [1:0][9:0] duty_active;
    logic [1:0][9:0] duty_written;
    logic [1:0] od_bit;

    function automatic logic pwm_mode(input logic [7:0] ctl);
        pwm_mode = (ctl[MODE_LSB + 2 +: 2] == MODE_PWM_TOP);
    endfunction

    function automatic logic [7:0] read_map(input logic [3:0] a, input unit_state_t s,
                                           input logic [1:0][7:0] cnt);
        case (a)
            ADDR_TB_A_COUNT: read_map = cnt[0];
            ADDR_TB_A_PERIOD: read_map = s.period[0];
            ADDR_TB_A_CONTROL: read_map = s.tb_control[0];
            ADDR_TB_B_COUNT: read_map = cnt[1];
            ADDR_TB_B_PERIOD: read_map = s.period[1];
            ADDR_TB_B_CONTROL: read_map = s.tb_control[1];
            ADDR_U4_DUTY_LOW: read_map = s.duty_low[0];
            ADDR_U4_DUTY_HIGH: read_map = s.duty_high[0];
            ADDR_U5_DUTY_LOW: read_map = s.duty_low[1];
            ADDR_U5_DUTY_HIGH: read_map = s.duty_high[1];
            ADDR_U4_CONTROL: read_map = s.unit_control[0];
            ADDR_U5_CONTROL: read_map = s.unit_control[1];
            ADDR_OPEN_DRAIN: read_map = s.open_drain;
            ADDR_TB_ASSIGN: read_map = {6'h00, s.assign_b};
            default: read_map = RESET_BYTE;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_tb
            assign count_we[g] = wr_i && (addr_i == ADDR_TB_A_COUNT + 4'(3 * g));
            assign control_we[g] = wr_i && (addr_i == ADDR_TB_A_CONTROL + 4'(3 * g));
            pwm_timebase u_tb (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .count_we_i(count_we[g]),
                .control_we_i(control_we[g]),
                .wdata_i(wdata_i),
                .period_i(cur_ff.period[g]),
                .control_i(cur_ff.tb_control[g]),
                .count_o(tb_count[g]),
                .fine_o(tb_fine[g]),
                .restart_o(tb_restart[g]),
                .post_event_o(post_event_o[g])
            );
        end
        for (g = 0; g < 2; g++) begin : gen_unit
            assign is_pwm[g] = pwm_mode(cur_ff.unit_control[g]);
            // each unit follows exactly one timebase
            assign sel_restart[g] = tb_restart[cur_ff.assign_b[g]]; // (R17)
            // count extended by two fine bits gives period in oscillator clocks times prescale
            assign sel_count[g] = {tb_count[cur_ff.assign_b[g]],
                                   tb_fine[cur_ff.assign_b[g]]}; // (R1)
            assign duty_active[g] = {cur_ff.duty_high[g], cur_ff.duty_hidden[g]}; // (R10)
            assign duty_written[g] = {cur_ff.duty_low[g],
                                      cur_ff.unit_control[g][DUTY_LOW_BITS_LSB +: 2]}; // (R6)
            assign od_bit[g] = cur_ff.open_drain[OD_UNIT_FOUR_BIT + g];
            // pin only drives when software made it an output
            assign pwm_oe_o[g] = !port_direction_i[g]
                && (!od_bit[g] || !cur_ff.out_latch[g]); // (R16) (R18)
            assign pwm_o[g] = cur_ff.out_latch[g];
        end
    endgenerate

    assign rdata_o = cur_ff.rdata;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rdata = rd_i ? read_map(addr_i, cur_ff, tb_count) : RESET_BYTE;
        for (int u = 0; u < 2; u++) begin
            // the set trails the restart by one clock, as the registered clear
            // trails the match, so high time is exactly duty times prescale clocks
            nxt_ff.restart_d[u] = sel_restart[u] && is_pwm[u];
            if (!is_pwm[u]) begin
                nxt_ff.out_latch[u] = 1'b0;
            end else begin
                if (sel_restart[u]) begin
                    // new duty takes effect only at the period boundary
                    nxt_ff.duty_high[u] = duty_written[u][9:2]; // (R4) (R8)
                    nxt_ff.duty_hidden[u] = duty_written[u][1:0]; // (R4) (R10)
                end
                if (cur_ff.restart_d[u]) begin
                    nxt_ff.out_latch[u] = (duty_active[u] != 10'h000); // (R3)
                end else if (duty_active[u] == sel_count[u]) begin
                    // a duty above the period never matches, so the pin stays high
                    nxt_ff.out_latch[u] = 1'b0; // (R7) (R11) (R12)
                end
            end
        end
        if (wr_i) begin
            case (addr_i)
                ADDR_TB_A_PERIOD: nxt_ff.period[0] = wdata_i;
                ADDR_TB_A_CONTROL: nxt_ff.tb_control[0] = wdata_i & TB_CONTROL_MASK;
                ADDR_TB_B_PERIOD: nxt_ff.period[1] = wdata_i;
                ADDR_TB_B_CONTROL: nxt_ff.tb_control[1] = wdata_i & TB_CONTROL_MASK;
                ADDR_U4_DUTY_LOW: nxt_ff.duty_low[0] = wdata_i;
                ADDR_U5_DUTY_LOW: nxt_ff.duty_low[1] = wdata_i;
                ADDR_U4_DUTY_HIGH: begin
                    if (!is_pwm[0]) begin
                        nxt_ff.duty_high[0] = wdata_i; // (R9)
                    end
                end
                ADDR_U5_DUTY_HIGH: begin
                    if (!is_pwm[1]) begin
                        nxt_ff.duty_high[1] = wdata_i; // (R9)
                    end
                end
                ADDR_U4_CONTROL: begin
                    nxt_ff.unit_control[0] = wdata_i & UNIT_CONTROL_MASK;
                    if (wdata_i == RESET_BYTE) begin
                        nxt_ff.out_latch[0] = 1'b0; // (R15)
                    end
                end
                ADDR_U5_CONTROL: begin
                    nxt_ff.unit_control[1] = wdata_i & UNIT_CONTROL_MASK;
                    if (wdata_i == RESET_BYTE) begin
                        nxt_ff.out_latch[1] = 1'b0; // (R15)
                    end
                end
                ADDR_OPEN_DRAIN: nxt_ff.open_drain = wdata_i & OPEN_DRAIN_MASK;
                ADDR_TB_ASSIGN: nxt_ff.assign_b = wdata_i[1:0];
                default: nxt_ff.rdata = nxt_ff.rdata;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff <= '0;
            cur_ff.period <= {PERIOD_RESET, PERIOD_RESET};
        end else if (ce_i) begin
            cur_ff <= nxt_ff;
        end
    end

    // checks
    a_restart_sets_pin: assert property (@(posedge clk_i) disable iff (rst_i) // (R3)
        ce_i && is_pwm[0] && cur_ff.restart_d[0] && duty_active[0] != 10'h000
        && !(wr_i && addr_i == ADDR_U4_CONTROL) |=> pwm_o[0])
        else $error("pin not set at restart");
    a_zero_duty_low: assert property (@(posedge clk_i) disable iff (rst_i) // (R3)
        ce_i && cur_ff.restart_d[0] && duty_active[0] == 10'h000 |=> !pwm_o[0])
        else $error("pin set with zero duty");
    a_duty_latched: assert property (@(posedge clk_i) disable iff (rst_i) // (R4)
        ce_i && is_pwm[0] && sel_restart[0]
        |=> duty_active[0] == $past(duty_written[0]))
        else $error("duty not latched at restart");
    a_duty_held: assert property (@(posedge clk_i) disable iff (rst_i) // (R8)
        ce_i && is_pwm[0] && !sel_restart[0] |=> $stable(duty_active[0]))
        else $error("active duty changed mid period");
    a_high_readonly: assert property (@(posedge clk_i) disable iff (rst_i) // (R9)
        ce_i && is_pwm[1] && wr_i && addr_i == ADDR_U5_DUTY_HIGH && !sel_restart[1]
        |=> $stable(cur_ff.duty_high[1]))
        else $error("duty high byte written in pwm mode");
    a_match_clears: assert property (@(posedge clk_i) disable iff (rst_i) // (R11)
        ce_i && is_pwm[0] && !cur_ff.restart_d[0] && duty_active[0] == sel_count[0]
        |=> !pwm_o[0])
        else $error("pin not cleared at duty match");
    a_control_clear: assert property (@(posedge clk_i) disable iff (rst_i) // (R15)
        ce_i && wr_i && addr_i == ADDR_U5_CONTROL && wdata_i == 8'h00 |=> !pwm_o[1])
        else $error("control clear left pin high");
    a_open_drain: assert property (@(posedge clk_i) disable iff (rst_i) // (R18)
        od_bit[0] && pwm_o[0] |-> !pwm_oe_o[0])
        else $error("open drain drove high");
    a_counter_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // (R2)
        ce_i && tb_restart[0] && !count_we[0] |=> tb_count[0] == 8'h00)
        else $error("counter not cleared after period match");
    c_restart: cover property (@(posedge clk_i) sel_restart[0] && is_pwm[0]);
    c_match: cover property (@(posedge clk_i) $fell(pwm_o[0]));
    c_unit_b_tb: cover property (@(posedge clk_i) cur_ff.assign_b[1] && $rose(pwm_o[1]));
    c_hold_high: cover property (@(posedge clk_i) pwm_o[0] && sel_restart[0]);
endmodule

// File: verification/pwm_load.sv
// behavioural load on one pwm pin: pull-up resistor plus a pulse meter
// assumes drive and enable come straight from the unit's pin outputs
`timescale 1ns/1ps
module pwm_load (
    // clock and meter control
    input wire logic clk_i,
    input wire logic meter_clr_i,
    // pin as driven by the unit
    input wire logic drive_i,
    input wire logic drive_oe_i,
    // observed level and meter
    output logic pin_o,
    output logic [15:0] high_cnt_o,
    output logic [7:0] rise_cnt_o
);
    logic last_ff;

    // an undriven pin is pulled up, so open-drain high needs no driver
    assign pin_o = drive_oe_i ? drive_i : 1'b1;

    // counts are exact over any whole number of periods, whatever the phase
    always_ff @(posedge clk_i) begin
        last_ff <= pin_o;
        if (meter_clr_i) begin
            high_cnt_o <= 16'h0000;
            rise_cnt_o <= 8'h00;
        end else begin
            high_cnt_o <= high_cnt_o + {15'h0000, pin_o};
            rise_cnt_o <= rise_cnt_o + {7'h00, pin_o & ~last_ff};
        end
    end
endmodule

// File: verification/ccp_pwm_mode_generator_bench.sv
// self-checking bench for the two-unit pwm block: register tasks, table of settings, edge cases
// assumes the register map of pwm_pkg and a load with pull-up on each pin
`timescale 1ns/1ps
module ccp_pwm_mode_generator_bench;
    import pwm_pkg::*;

    typedef struct packed {
        logic unit;
        logic tbsel;
        logic [7:0] per;
        logic [6:0] tctl;
        logic [9:0] duty;
        logic [15:0] exp_t;
        logic [15:0] exp_h;
    } row_t;

    // unit, timebase, period, timer control, duty, period cycles, high cycles
    row_t rows [8] = '{
        '{1'h0, 1'h0, 8'h03, 7'h04, 10'h005, 16'h0010, 16'h0005},
        '{1'h0, 1'h0, 8'h03, 7'h2D, 10'h00A, 16'h0040, 16'h0028},
        '{1'h0, 1'h0, 8'h01, 7'h7E, 10'h003, 16'h0080, 16'h0030},
        '{1'h0, 1'h0, 8'h01, 7'h07, 10'h007, 16'h0080, 16'h0070},
        '{1'h0, 1'h0, 8'h03, 7'h04, 10'h000, 16'h0010, 16'h0000},
        '{1'h0, 1'h0, 8'h03, 7'h0C, 10'h010, 16'h0010, 16'h0010},
        '{1'h1, 1'h1, 8'h07, 7'h14, 10'h013, 16'h0020, 16'h0013},
        '{1'h0, 1'h1, 8'h07, 7'h04, 10'h009, 16'h0020, 16'h0009}
    };

    logic clk_i, rst_i, ce_i, wr_i, rd_i, meter_clr;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [1:0] port_direction_i, pwm_o, pwm_oe_o, pin;
    logic [1:0][15:0] hi_cnt;
    logic [1:0][7:0] rise_cnt;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    pwm_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .port_direction_i(port_direction_i), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o),
        .post_event_o());

    for (genvar g = 0; g < 2; g++) begin : g_load
        pwm_load u_load (.clk_i(clk_i), .meter_clr_i(meter_clr), .drive_i(pwm_o[g]),
            .drive_oe_i(pwm_oe_o[g]), .pin_o(pin[g]), .high_cnt_o(hi_cnt[g]),
            .rise_cnt_o(rise_cnt[g]));
    end

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // the whole run needs a few thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobes drop for one cycle between accesses, never reassigned in one step
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(what, {8'h00, exp}, {8'h00, rdata_o});
        @(posedge clk_i);
    endtask

    task automatic setup(input row_t r);
        logic [3:0] base, uctl;
        base = r.tbsel ? ADDR_TB_B_COUNT : ADDR_TB_A_COUNT;
        uctl = r.unit ? ADDR_U5_CONTROL : ADDR_U4_CONTROL;
        wr_reg(ADDR_TB_ASSIGN, {6'h00, r.tbsel, r.tbsel});
        wr_reg(base + 4'h1, r.per);
        wr_reg(r.unit ? ADDR_U5_DUTY_LOW : ADDR_U4_DUTY_LOW, r.duty[9:2]);
        wr_reg(uctl, {2'h0, r.duty[1:0], 4'h0});
        port_direction_i <= 2'h0;
        wr_reg(base, 8'h00);
        wr_reg(base + 4'h2, {1'h0, r.tctl});
        wr_reg(uctl, {2'h0, r.duty[1:0], 4'hC});
    endtask

    // window of four whole periods after two periods plus eight cycles of settling
    task automatic measure(input row_t r);
        repeat (2 * r.exp_t + 8) @(posedge clk_i);
        meter_clr <= 1'b1;
        @(posedge clk_i);
        meter_clr <= 1'b0;
        repeat (4 * r.exp_t) @(posedge clk_i);
        #1;
        check("high cycles", 16'(4 * r.exp_h), hi_cnt[r.unit]);
        check("rising edges", 16'((r.exp_h != 0 && r.exp_h != r.exp_t) ? 4 : 0),
            {8'h00, rise_cnt[r.unit]});
    endtask

    task automatic wait_rise();
        int n;
        n = 0;
        while (pwm_o[0] !== 1'b0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        while (pwm_o[0] !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        check("restart seen", 16'h0001, {15'h0000, n < 400});
    endtask

    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        meter_clr = 1'b1;
        port_direction_i = 2'h3;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wr_reg(4'hF, 8'hA5);
        for (int a = 0; a < 16; a++) begin
            rd_chk(a[3:0], (a == 1 || a == 4) ? 8'hFF : 8'h00, "reset value");
        end
        wr_reg(ADDR_OPEN_DRAIN, 8'hFF);
        rd_chk(ADDR_OPEN_DRAIN, 8'h1F, "open drain bits");
        wr_reg(ADDR_OPEN_DRAIN, 8'h00);
        for (int i = 0; i < 8; i++) begin
            setup(rows[i]);
            measure(rows[i]);
        end
        // duty written mid-period waits for the restart
        setup(rows[0]);
        wait_rise();
        wr_reg(ADDR_U4_DUTY_LOW, 8'h03);
        rd_chk(ADDR_U4_DUTY_HIGH, 8'h01, "duty high before restart");
        repeat (20) @(posedge clk_i);
        rd_chk(ADDR_U4_DUTY_HIGH, 8'h03, "duty high after restart");
        wr_reg(ADDR_U4_DUTY_HIGH, 8'hAA);
        rd_chk(ADDR_U4_DUTY_HIGH, 8'h03, "duty high write ignored");
        measure('{1'h0, 1'h0, 8'h03, 7'h04, 10'h00D, 16'h0010, 16'h000D});
        // open drain, unit off, pin released
        setup(rows[5]);
        repeat (40) @(posedge clk_i);
        wr_reg(ADDR_OPEN_DRAIN, 8'h08);
        check("oe while high", 16'h0000, {15'h0000, pwm_oe_o[0]});
        check("pulled-up pin", 16'h0001, {15'h0000, pin[0]});
        wr_reg(ADDR_U4_CONTROL, 8'h00);
        check("latch after clear", 16'h0000, {15'h0000, pwm_o[0]});
        check("oe while low", 16'h0001, {15'h0000, pwm_oe_o[0]});
        port_direction_i <= 2'h1;
        @(posedge clk_i);
        #1;
        check("oe as input", 16'h0000, {15'h0000, pwm_oe_o[0]});
        // reset in mid-run
        wr_reg(ADDR_OPEN_DRAIN, 8'h00);
        setup(rows[0]);
        wait_rise();
        // enable low freezes the pin mid high time; it would have fallen by now
        ce_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        check("frozen pin", 16'h0001, {15'h0000, pwm_o[0]});
        ce_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check("outputs in reset", 16'h0000, {14'h0000, pwm_o});
        @(posedge clk_i);
        rd_chk(ADDR_TB_A_PERIOD, 8'hFF, "period after reset");
        finish_test();
    end
endmodule
